// File: verilog/lcdfd_cfg.svh
`ifndef LCDFD_CFG_SVH
`define LCDFD_CFG_SVH
`define LCDFD_OFS_MEM0 12'h000
`define LCDFD_OFS_FRR 12'h050
`define LCDFD_OFS_CCR 12'h054
`define LCDFD_OFS_CTRL 12'h058
`define LCDFD_OFS_STAT 12'h05C
`define LCDFD_MEM_WORDS 20
`define LCDFD_REGS_PER_COM 5
`define LCDFD_FRR_MASK 8'h77
`define LCDFD_CCR_MASK 8'h0F
`define LCDFD_CTRL_MASK 8'h03
`define LCDFD_TAP_HI 6
`define LCDFD_TAP_LO 4
`define LCDFD_DIV_HI 2
`define LCDFD_DIV_LO 0
`define LCDFD_DUTY_HI 1
`define LCDFD_DUTY_LO 0
`define LCDFD_PRE_LAST_T0 12'h000F
`define LCDFD_PRE_LAST_T1 12'h003F
`define LCDFD_PRE_LAST_T2 12'h007F
`define LCDFD_PRE_LAST_T3 12'h00FF
`define LCDFD_PRE_LAST_T4 12'h01FF
`define LCDFD_PRE_LAST_T5 12'h03FF
`define LCDFD_PRE_LAST_T6 12'h07FF
`define LCDFD_PRE_LAST_T7 12'h0FFF
`define LCDFD_K_NORMAL 4'h8
`define LCDFD_K_THIRD 4'h6
`define LCDFD_RESP_OKAY 2'h0
`define LCDFD_RESP_SLVERR 2'h2
`endif

// File: verilog/lcdfd_pkg.sv
package lcdfd_pkg;
  typedef enum logic [1:0] {
    LCDFD_DUTY_STATIC,
    LCDFD_DUTY_HALF,
    LCDFD_DUTY_THIRD,
    LCDFD_DUTY_QUARTER
  } lcdfd_duty_t;
  typedef enum logic {
    LCDFD_WR_IDLE,
    LCDFD_WR_RESP
  } lcdfd_wr_state_t;
endpackage : lcdfd_pkg

// File: verilog/lcdfd_top.sv
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "lcdfd_cfg.svh"
module lcdfd_top
  import lcdfd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Panel side
  output logic frame_start,
  output logic [3:0] contrast_level,
  output logic [24:0] common_line_0,
  output logic [24:0] common_line_1,
  output logic [24:0] common_line_2,
  output logic [24:0] common_line_3
);

  // Register storage
  logic [7:0] seg_mem [0:`LCDFD_MEM_WORDS-1];
  logic [7:0] next_seg_mem [0:`LCDFD_MEM_WORDS-1];
  logic [7:0] frr, next_frr;
  logic [7:0] ccr, next_ccr;
  logic [7:0] ctrl, next_ctrl;
  logic [3:0] next_contrast_level;
  logic [24:0] com_q [0:3];
  logic [24:0] next_com [0:3];

  // Bus state
  logic [11:0] aw_addr, next_aw_addr;
  logic aw_held, next_aw_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic w_held, next_w_held;
  lcdfd_wr_state_t wr_state, next_wr_state;
  logic [1:0] bresp_q, next_bresp;
  logic rvalid_q, next_rvalid;
  logic [31:0] rdata_q, next_rdata;
  logic [1:0] rresp_q, next_rresp;

  // Divider chain
  logic [11:0] pre_cnt, next_pre_cnt;
  logic [2:0] div_cnt, next_div_cnt;
  logic [2:0] k_cnt, next_k_cnt;
  logic next_frame_start;
  logic [11:0] pre_last;
  logic [2:0] k_last;
  logic frame_wrap;
  logic frame_clean, next_frame_clean;

  logic do_write;
  logic [11:0] wr_ofs;
  logic wr_hit;
  logic [7:0] wr_byte;
  lcdfd_duty_t duty;

  assign duty = lcdfd_duty_t'(ctrl[`LCDFD_DUTY_HI:`LCDFD_DUTY_LO]);
  assign do_write = aw_held && w_held && (wr_state == LCDFD_WR_IDLE);
  assign wr_ofs = {aw_addr[11:2], 2'b00};
  assign wr_byte = w_data[7:0];

  // Prescaler tap N
  always_comb begin
    case (frr[`LCDFD_TAP_HI:`LCDFD_TAP_LO])
      3'h0: pre_last = `LCDFD_PRE_LAST_T0;
      3'h1: pre_last = `LCDFD_PRE_LAST_T1;
      3'h2: pre_last = `LCDFD_PRE_LAST_T2;
      3'h3: pre_last = `LCDFD_PRE_LAST_T3;
      3'h4: pre_last = `LCDFD_PRE_LAST_T4;
      3'h5: pre_last = `LCDFD_PRE_LAST_T5;
      3'h6: pre_last = `LCDFD_PRE_LAST_T6;
      default: pre_last = `LCDFD_PRE_LAST_T7;
    endcase
    if (duty == LCDFD_DUTY_THIRD) begin
      k_last = 3'(`LCDFD_K_THIRD - 4'h1);
    end else begin
      k_last = 3'(`LCDFD_K_NORMAL - 4'h1);
    end
  end

  assign frame_wrap = (pre_cnt >= pre_last) &&
                      (div_cnt >= frr[`LCDFD_DIV_HI:`LCDFD_DIV_LO]) && (k_cnt >= k_last);

  always_comb begin
    next_pre_cnt = pre_cnt + 12'h0001;
    next_div_cnt = div_cnt;
    next_k_cnt = k_cnt;
    next_frame_start = 1'b0;
    if (pre_cnt >= pre_last) begin
      next_pre_cnt = 12'h0000;
      next_div_cnt = div_cnt + 3'h1;
      if (div_cnt >= frr[`LCDFD_DIV_HI:`LCDFD_DIV_LO]) begin
        next_div_cnt = 3'h0;
        next_k_cnt = k_cnt + 3'h1;
        if (k_cnt >= k_last) begin
          next_k_cnt = 3'h0;
          next_frame_start = 1'b1;
        end
      end
    end
  end

  // Settings unchanged since the last wrap; a wrap restarts from zero
  always_comb begin
    next_frame_clean = frame_clean;
    if (next_frr != frr || next_ctrl != ctrl) begin
      next_frame_clean = 1'b0;
    end
    if (frame_wrap) begin
      next_frame_clean = 1'b1;
    end
  end

  // Write path
  always_comb begin
    next_aw_addr = aw_addr;
    next_aw_held = aw_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_w_held = w_held;
    next_wr_state = wr_state;
    next_bresp = bresp_q;
    next_frr = frr;
    next_ccr = ccr;
    next_ctrl = ctrl;
    wr_hit = 1'b0;
    for (int i = 0; i < `LCDFD_MEM_WORDS; i++) begin
      next_seg_mem[i] = seg_mem[i];
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_addr = s_axi_awaddr;
      next_aw_held = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_w_held = 1'b1;
    end
    case (wr_state)
      LCDFD_WR_IDLE: begin
        if (do_write) begin
          for (int i = 0; i < `LCDFD_MEM_WORDS; i++) begin
            if (wr_ofs == `LCDFD_OFS_MEM0 + 12'(4 * i)) begin
              wr_hit = 1'b1;
              if (w_strb[0]) begin
                next_seg_mem[i] = wr_byte;
              end
            end
          end
          if (wr_ofs == `LCDFD_OFS_FRR) begin
            wr_hit = 1'b1;
            if (w_strb[0]) begin
              next_frr = wr_byte & `LCDFD_FRR_MASK;
            end
          end
          if (wr_ofs == `LCDFD_OFS_CCR) begin
            wr_hit = 1'b1;
            if (w_strb[0]) begin
              next_ccr = wr_byte & `LCDFD_CCR_MASK;
            end
          end
          if (wr_ofs == `LCDFD_OFS_CTRL) begin
            wr_hit = 1'b1;
            if (w_strb[0]) begin
              next_ctrl = wr_byte & `LCDFD_CTRL_MASK;
            end
          end
          if (wr_ofs == `LCDFD_OFS_STAT) begin
            wr_hit = 1'b1;
          end
          next_bresp = wr_hit ? `LCDFD_RESP_OKAY : `LCDFD_RESP_SLVERR;
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_wr_state = LCDFD_WR_RESP;
        end
      end
      LCDFD_WR_RESP: begin
        if (s_axi_bready) begin
          next_wr_state = LCDFD_WR_IDLE;
        end
      end
      default: next_wr_state = LCDFD_WR_IDLE;
    endcase
  end

  // Read path
  always_comb begin
    next_rvalid = rvalid_q;
    next_rdata = rdata_q;
    next_rresp = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = 32'h0000_0000;
      next_rresp = `LCDFD_RESP_SLVERR;
      for (int i = 0; i < `LCDFD_MEM_WORDS; i++) begin
        if ({s_axi_araddr[11:2], 2'b00} == `LCDFD_OFS_MEM0 + 12'(4 * i)) begin
          next_rdata = {24'h00_0000, seg_mem[i]};
          next_rresp = `LCDFD_RESP_OKAY;
        end
      end
      case ({s_axi_araddr[11:2], 2'b00})
        `LCDFD_OFS_FRR: begin
          next_rdata = {24'h00_0000, frr & `LCDFD_FRR_MASK};
          next_rresp = `LCDFD_RESP_OKAY;
        end
        `LCDFD_OFS_CCR: begin
          next_rdata = {24'h00_0000, ccr & `LCDFD_CCR_MASK};
          next_rresp = `LCDFD_RESP_OKAY;
        end
        `LCDFD_OFS_CTRL: begin
          next_rdata = {24'h00_0000, ctrl};
          next_rresp = `LCDFD_RESP_OKAY;
        end
        `LCDFD_OFS_STAT: begin
          next_rdata = {20'h0_0000, contrast_level, 5'h00, k_cnt};
          next_rresp = `LCDFD_RESP_OKAY;
        end
        default: begin
        end
      endcase
    end
  end

  // Panel image and contrast, loaded at frame start
  always_comb begin
    next_contrast_level = contrast_level;
    for (int c = 0; c < 4; c++) begin
      next_com[c] = com_q[c];
    end
    if (frame_wrap) begin
      next_contrast_level = ccr[3:0];
      for (int c = 0; c < 4; c++) begin
        next_com[c] = {seg_mem[c * `LCDFD_REGS_PER_COM + 3][0],
                       seg_mem[c * `LCDFD_REGS_PER_COM + 2],
                       seg_mem[c * `LCDFD_REGS_PER_COM + 1],
                       seg_mem[c * `LCDFD_REGS_PER_COM]};
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `LCDFD_MEM_WORDS; i++) begin
        seg_mem[i] <= 8'h00;
      end
      for (int c = 0; c < 4; c++) begin
        com_q[c] <= 25'h000_0000;
      end
      frr <= 8'h00;
      ccr <= 8'h00;
      ctrl <= 8'h00;
      contrast_level <= 4'h0;
      aw_addr <= 12'h000;
      aw_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      w_held <= 1'b0;
      wr_state <= LCDFD_WR_IDLE;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'h0;
      pre_cnt <= 12'h000;
      div_cnt <= 3'h0;
      k_cnt <= 3'h0;
      frame_start <= 1'b0;
      frame_clean <= 1'b1;
    end else begin
      for (int i = 0; i < `LCDFD_MEM_WORDS; i++) begin
        seg_mem[i] <= next_seg_mem[i];
      end
      for (int c = 0; c < 4; c++) begin
        com_q[c] <= next_com[c];
      end
      frr <= next_frr;
      ccr <= next_ccr;
      ctrl <= next_ctrl;
      contrast_level <= next_contrast_level;
      aw_addr <= next_aw_addr;
      aw_held <= next_aw_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      w_held <= next_w_held;
      wr_state <= next_wr_state;
      bresp_q <= next_bresp;
      rvalid_q <= next_rvalid;
      rdata_q <= next_rdata;
      rresp_q <= next_rresp;
      pre_cnt <= next_pre_cnt;
      div_cnt <= next_div_cnt;
      k_cnt <= next_k_cnt;
      frame_start <= next_frame_start;
      frame_clean <= next_frame_clean;
    end
  end

  assign s_axi_awready = !aw_held && (wr_state == LCDFD_WR_IDLE);
  assign s_axi_wready = !w_held && (wr_state == LCDFD_WR_IDLE);
  assign s_axi_bvalid = (wr_state == LCDFD_WR_RESP);
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign common_line_0 = com_q[0];
  assign common_line_1 = com_q[1];
  assign common_line_2 = com_q[2];
  assign common_line_3 = com_q[3];

  // Assertions
  sequence frame_edge_s;
    frame_start;
  endsequence

  AST_STROBE_ONE: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_edge_s |=> !frame_start)
    else $error("frame strobe wider than one cycle");
  AST_FAST_FRAME_GAP: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_edge_s |=> !frame_start [*8])
    else $error("frames closer than minimum period");
  AST_MIN_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn)
    (frame_start && frr == 8'h00 && ctrl == 8'h00 && $stable(frr) && $stable(ctrl))
    |-> ##[1:128] (frame_start || !frame_clean))
    else $error("fastest frame period not met");
  AST_K_BOUND: assert property (@(posedge aclk) disable iff (!aresetn)
    (frame_wrap && frame_clean && duty != LCDFD_DUTY_THIRD) |-> k_cnt == 3'h7)
    else $error("duty factor eight wrong");
  AST_K_THIRD: assert property (@(posedge aclk) disable iff (!aresetn)
    (frame_wrap && frame_clean && duty == LCDFD_DUTY_THIRD) |-> k_cnt == 3'h5)
    else $error("third duty factor wrong");
  AST_DIV_BOUND: assert property (@(posedge aclk) disable iff (!aresetn)
    (frame_wrap && frame_clean) |-> div_cnt == frr[`LCDFD_DIV_HI:`LCDFD_DIV_LO])
    else $error("divider wrap count wrong");
  AST_PRE_BOUND: assert property (@(posedge aclk) disable iff (!aresetn)
    (frame_wrap && frame_clean) |-> pre_cnt == pre_last)
    else $error("prescaler tap wrong");
  AST_FRR_RSV: assert property (@(posedge aclk) disable iff (!aresetn)
    frr[3] == 1'b0 && frr[7] == 1'b0)
    else $error("reserved frame bit set");
  AST_CCR_RSV: assert property (@(posedge aclk) disable iff (!aresetn)
    ccr[7:4] == 4'h0)
    else $error("reserved contrast bits set");
  AST_CONTRAST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    !frame_wrap |=> $stable(contrast_level))
    else $error("contrast changed mid frame");
  AST_SEG_LOAD: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_wrap |=> common_line_1 == {$past(seg_mem[8][0]), $past(seg_mem[7]),
                                     $past(seg_mem[6]), $past(seg_mem[5])})
    else $error("segment image wrong");
  AST_MEM_STORE: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_ofs == `LCDFD_OFS_MEM0 + 12'h04C && w_strb[0])
    |=> seg_mem[19] == $past(wr_byte))
    else $error("storage byte not written");

endmodule : lcdfd_top

// File: testbench/lcdfd_panel_model.sv
`timescale 1ns/1ps
module lcdfd_panel_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Drive from the controller
  input wire logic frame_start,
  input wire logic [3:0] contrast_level,
  input wire logic [24:0] common_line_0,
  input wire logic [24:0] common_line_1,
  input wire logic [24:0] common_line_2,
  input wire logic [24:0] common_line_3
);
  // Lit segments per common and drive level, as latched by the glass each frame
  logic [24:0] lit [4];
  logic [3:0] drive;
  always @(posedge aclk) begin
    if (!aresetn) begin
      drive <= 4'h0;
    end else if (frame_start) begin
      lit[0] <= common_line_0;
      lit[1] <= common_line_1;
      lit[2] <= common_line_2;
      lit[3] <= common_line_3;
      drive <= contrast_level;
    end
  end
endmodule : lcdfd_panel_model

// File: testbench/tb_lcd_frame_divider_and_segment_memory.sv
`timescale 1ns/1ps
`include "lcdfd_cfg.svh"
module tb_lcd_frame_divider_and_segment_memory
  import lcdfd_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, contrast_level;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic frame_start;
  logic [24:0] common_line_0, common_line_1, common_line_2, common_line_3;
  logic [7:0] img [20];
  int num_errors = 0;
  int check_count = 0;

  lcdfd_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .frame_start(frame_start),
    .contrast_level(contrast_level), .common_line_0(common_line_0),
    .common_line_1(common_line_1), .common_line_2(common_line_2),
    .common_line_3(common_line_3));

  lcdfd_panel_model panel (.aclk(aclk), .aresetn(aresetn), .frame_start(frame_start),
    .contrast_level(contrast_level), .common_line_0(common_line_0),
    .common_line_1(common_line_1), .common_line_2(common_line_2),
    .common_line_3(common_line_3));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic conclude();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Cycles from call until frame_start is seen high
  task automatic wait_frame(output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (frame_start !== 1'b1);
  endtask : wait_frame

  function automatic int kf(input logic [1:0] dt);
    return (dt == LCDFD_DUTY_THIRD) ? 6 : 8;
  endfunction : kf

  function automatic int nf(input int t);
    return (t == 0) ? 16 : (32 << t);
  endfunction : nf

  function automatic logic [24:0] exp_line(input int c);
    return {img[5 * c + 3][0], img[5 * c + 2], img[5 * c + 1], img[5 * c]};
  endfunction : exp_line

  initial begin
    repeat (80000) @(posedge aclk);
    num_errors++;
    conclude();
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] c;
    int p, dv, tp;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'h1;
    aresetn = 1'b0;
    void'($urandom(48));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 22; i++) begin
      rd(12'(4 * i), d, r);
      chk(d, 32'h0000_0000);
    end
    rd(12'h060, d, r);
    chk({d[29:0], r}, 32'h0000_0002);
    wr(12'h060, 32'hFFFF_FFFF, r);
    chk(32'(r), 32'h0000_0002);
    wr(`LCDFD_OFS_FRR, 32'hFFFF_FFFF, r);
    rd(`LCDFD_OFS_FRR, d, r);
    chk(d, 32'h0000_0077);
    wr(`LCDFD_OFS_CCR, 32'hFFFF_FFFF, r);
    rd(`LCDFD_OFS_CCR, d, r);
    chk(d, 32'h0000_000F);
    wr(`LCDFD_OFS_FRR, 32'h0000_0000, r);
    for (int i = 0; i < 20; i++) begin
      img[i] = 8'($urandom);
      wr(12'(4 * i), {24'($urandom), img[i]}, r);
      rd(12'(4 * i), d, r);
      chk(d, {24'h00_0000, img[i]});
    end
    // Contrast must wait for the next frame boundary
    wait_frame(p);
    @(negedge aclk);
    chk(32'(contrast_level), 32'h0000_000F);
    c = 4'($urandom % 15);
    @(posedge aclk);
    wr(`LCDFD_OFS_CCR, 32'(c), r);
    chk(32'(contrast_level), 32'h0000_000F);
    wait_frame(p);
    @(negedge aclk);
    chk(32'(panel.drive), 32'(c));
    for (int i = 0; i < 4; i++) chk(32'(panel.lit[i]), 32'(exp_line(i)));
    @(posedge aclk);
    for (int dt = 0; dt < 4; dt++) begin
      for (int j = 0; j < 3; j++) begin
        dv = (j == 0) ? 0 : (j == 1) ? 7 : int'($urandom % 8);
        tp = (j == 0) ? 2 : (j == 1) ? 0 : int'($urandom % 2);
        wr(`LCDFD_OFS_CTRL, 32'(dt), r);
        wr(`LCDFD_OFS_FRR, 32'(tp * 16 + dv), r);
        wait_frame(p);
        wait_frame(p);
        chk(32'(p), 32'(kf(2'(dt)) * nf(tp) * (dv + 1)));
      end
    end
    conclude();
  end
endmodule : tb_lcd_frame_divider_and_segment_memory
